/* hw/itx_regs.svh */
`ifndef ITX_REGS_SVH
`define ITX_REGS_SVH
`define ITX_OFF_CTRL_SET   12'h000
`define ITX_OFF_STATUS     12'h004
`define ITX_OFF_DATA       12'h008
`define ITX_OFF_SCL_HIGH   12'h010
`define ITX_OFF_SCL_LOW    12'h014
`define ITX_OFF_CTRL_CLR   12'h018
`define ITX_BIT_EN         6
`define ITX_BIT_STA        5
`define ITX_BIT_STO        4
`define ITX_BIT_SI         3
`define ITX_BIT_AA         2
`define ITX_CTRL_MASK      8'h7c
`define ITX_RST_CTRL       8'h00
`define ITX_RST_STATUS     8'hf8
`define ITX_RST_SCL        16'h0004
`define ITX_ST_START       8'h08
`define ITX_ST_RSTART      8'h10
`define ITX_ST_AW_ACK      8'h18
`define ITX_ST_AW_NACK     8'h20
`define ITX_ST_D_ACK       8'h28
`define ITX_ST_D_NACK      8'h30
`define ITX_ST_ARB         8'h38
`define ITX_ST_AR_ACK      8'h40
`define ITX_ST_AR_NACK     8'h48
`define ITX_ST_IDLE        8'hf8
`define ITX_FREE_NS        4700
`define ITX_CLK_MHZ        250
`define ITX_FREE_CYC       ((`ITX_FREE_NS * `ITX_CLK_MHZ + 999) / 1000)
`endif

/* hw/itx_pkg.sv */
package itx_pkg;
    typedef enum logic [7:0] {
        ITX_IDLE  = 8'h01,
        ITX_START = 8'h02,
        ITX_BITLO = 8'h04,
        ITX_BITHI = 8'h08,
        ITX_HOLD  = 8'h10,
        ITX_STOP  = 8'h20,
        ITX_ARBW  = 8'h40,
        ITX_RSTRT = 8'h80
    } itx_state_t;
endpackage

/* hw/itx_master_tx.sv */
// Overview of operation
// - Address phase sends seven address bits then direction bit, high read, low write
// - Acknowledge slot: low means acknowledge, high means not-acknowledge
// - While interrupt flag is set the transfer waits with SCL held low
// - Nothing happens on the bus unless the enable bit is one
// - With ack-enable clear the block never answers as a slave
// - Start bit set: wait for free bus, then send START
// - After START, set interrupt flag and report status 0x08
// - After address, report 0x18, 0x20 or 0x38; here a read address reports 0x40 or 0x48
// - After repeated START send loaded address; read bit selects receive operation
// - Flag cleared with start and stop clear sends byte and samples acknowledge
// - Flag cleared with only start set issues repeated START
// - Flag cleared with only stop set issues STOP and hardware clears stop bit
// - Flag cleared with start and stop set: STOP, then START, stop bit cleared
// - After data byte report 0x28 on acknowledge, 0x30 on not-acknowledge
// - Address not acknowledged reports 0x20 with same four responses
// - Arbitration loss reports 0x38; start bit set retries START when free
// - Status holds code in upper five bits, low three zero, stable while flagged
// - Set address sets ones, clear address clears ones, set address reads control
//
// Chosen here: the register offsets and the APB interface to the registers.
`timescale 1ns/10ps
`include "itx_regs.svh"
module itx_master_tx
    import itx_pkg::*;
(
    input  wire logic        CLOCK_I,
    input  wire logic        NRST_I,
    input  wire logic        PSEL_I,
    input  wire logic        PENABLE_I,
    input  wire logic        PWRITE_I,
    input  wire logic [11:0] PADDR_I,
    input  wire logic [31:0] PWDATA_I,
    output logic      [31:0] PRDATA_O,
    output logic             PREADY_O,
    output logic             PSLVERR_O,
    input  wire logic        SCL_I,
    output logic             SCL_O,
    output logic             SCL_OE_N_O,
    input  wire logic        SDA_I,
    output logic             SDA_O,
    output logic             SDA_OE_N_O,
    output logic             MASTER_RECEIVE_OP_O
);
    logic [7:0]  control_q;
    logic [7:0]  state_code_q;
    logic [7:0]  shift_q;
    logic [15:0] scl_high_q;
    logic [15:0] scl_low_q;
    logic [2:0]  scl_sync_q;
    logic [2:0]  sda_sync_q;
    logic        scl_s_q;
    logic        sda_s_q;
    logic        scl_drv_low_q;
    logic        sda_drv_low_q;
    logic        busy_q;
    logic [15:0] free_cnt_q;
    logic [15:0] tmr_q;
    logic [3:0]  bit_q;
    logic        arb_lost_q;
    logic        sda_lag_q;
    logic        addr_phase_q;
    logic        was_start_q;
    logic        mrx_q;
    logic        ack_q;
    itx_state_t  st_q;

    logic        wr_acc;
    logic        rd_acc;
    logic        si;
    logic        bus_free;
    logic        tmr_done;
    logic        si_set;
    logic [7:0]  si_code;

    function automatic logic hit(input logic [11:0] a, input logic [11:0] off);
        return a == off;
    endfunction

    assign wr_acc   = PSEL_I && PENABLE_I && PWRITE_I;
    assign rd_acc   = PSEL_I && !PENABLE_I && !PWRITE_I;
    assign si       = control_q[`ITX_BIT_SI];
    assign bus_free = !busy_q && free_cnt_q >= 16'(`ITX_FREE_CYC);
    assign tmr_done = tmr_q == 16'h0000;

    // Pin sampling; only the agreed second and third stages are used
    always_ff @(posedge CLOCK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            scl_sync_q <= 3'h7;
            sda_sync_q <= 3'h7;
            scl_s_q    <= 1'b1;
            sda_s_q    <= 1'b1;
        end else begin
            scl_sync_q <= {scl_sync_q[1:0], SCL_I};
            sda_sync_q <= {sda_sync_q[1:0], SDA_I};
            if (scl_sync_q[1] == scl_sync_q[2]) begin
                scl_s_q <= scl_sync_q[2];
            end
            if (sda_sync_q[1] == sda_sync_q[2]) begin
                sda_s_q <= sda_sync_q[2];
            end
        end
    end

    // Bus monitor for START/STOP by anyone
    always_ff @(posedge CLOCK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            busy_q     <= 1'b0;
            free_cnt_q <= 16'h0000;
        end else begin
            if (scl_s_q && sda_s_q && !busy_q && free_cnt_q != 16'hffff) begin
                free_cnt_q <= free_cnt_q + 16'h0001;
            end else if (!(scl_s_q && sda_s_q)) begin
                free_cnt_q <= 16'h0000;
            end
            if (scl_s_q && sda_sync_q[2] != sda_s_q && sda_sync_q[1] == sda_sync_q[2]) begin
                busy_q <= !sda_sync_q[2];
            end
        end
    end

    // Hardware events for the flag
    always_comb begin
        si_set  = 1'b0;
        si_code = `ITX_ST_IDLE;
        if (st_q == ITX_START && tmr_done && scl_s_q) begin
            si_set  = 1'b1;
            si_code = was_start_q ? `ITX_ST_RSTART : `ITX_ST_START;
        end else if (st_q == ITX_BITHI && tmr_done && bit_q == 4'h8) begin
            si_set = 1'b1;
            if (addr_phase_q && mrx_q) begin
                si_code = sda_s_q ? `ITX_ST_AR_NACK : `ITX_ST_AR_ACK;
            end else if (addr_phase_q) begin
                si_code = sda_s_q ? `ITX_ST_AW_NACK : `ITX_ST_AW_ACK;
            end else begin
                si_code = sda_s_q ? `ITX_ST_D_NACK : `ITX_ST_D_ACK;
            end
        end else if (st_q == ITX_ARBW && tmr_done) begin
            si_set  = 1'b1;
            si_code = `ITX_ST_ARB;
        end
    end

    // Control register: set/clear aliases, hardware flag and stop clear
    always_ff @(posedge CLOCK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            control_q <= `ITX_RST_CTRL;
        end else begin
            if (wr_acc && hit(PADDR_I, `ITX_OFF_CTRL_SET)) begin
                control_q <= control_q | (PWDATA_I[7:0] & `ITX_CTRL_MASK);
            end else if (wr_acc && hit(PADDR_I, `ITX_OFF_CTRL_CLR)) begin
                control_q <= control_q & ~(PWDATA_I[7:0] & `ITX_CTRL_MASK);
            end
            if (st_q == ITX_STOP && tmr_done) begin
                control_q[`ITX_BIT_STO] <= 1'b0;
            end
            if (si_set) begin
                control_q[`ITX_BIT_SI] <= 1'b1; // Set wins over clear
            end
            if (!control_q[`ITX_BIT_EN]) begin
                control_q[`ITX_BIT_SI]  <= 1'b0;
                control_q[`ITX_BIT_STO] <= 1'b0;
            end
        end
    end

    // Status code latched on flag set, stable until cleared
    always_ff @(posedge CLOCK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            state_code_q <= `ITX_RST_STATUS;
        end else if (si_set) begin
            state_code_q <= {si_code[7:3], 3'h0};
        end else if (!si && st_q == ITX_IDLE) begin
            state_code_q <= `ITX_ST_IDLE;
        end
    end

    // Other software registers
    always_ff @(posedge CLOCK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            scl_high_q <= `ITX_RST_SCL;
            scl_low_q  <= `ITX_RST_SCL;
        end else if (wr_acc) begin
            if (hit(PADDR_I, `ITX_OFF_SCL_HIGH)) begin
                scl_high_q <= PWDATA_I[15:0];
            end
            if (hit(PADDR_I, `ITX_OFF_SCL_LOW)) begin
                scl_low_q <= PWDATA_I[15:0];
            end
        end
    end

    // APB read data and response; zero wait states
    always_ff @(posedge CLOCK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            PRDATA_O  <= 32'h0000_0000;
            PREADY_O  <= 1'b0;
            PSLVERR_O <= 1'b0;
        end else begin
            PREADY_O  <= PSEL_I && !PENABLE_I;
            PSLVERR_O <= 1'b0;
            if (rd_acc) begin
                case (PADDR_I)
                    `ITX_OFF_CTRL_SET: PRDATA_O <= {24'h0, control_q};
                    `ITX_OFF_STATUS:   PRDATA_O <= {24'h0, state_code_q};
                    `ITX_OFF_DATA:     PRDATA_O <= {24'h0, shift_q};
                    `ITX_OFF_SCL_HIGH: PRDATA_O <= {16'h0, scl_high_q};
                    `ITX_OFF_SCL_LOW:  PRDATA_O <= {16'h0, scl_low_q};
                    default: begin
                        PRDATA_O  <= 32'h0000_0000;
                        PSLVERR_O <= !hit(PADDR_I, `ITX_OFF_CTRL_CLR);
                    end
                endcase
            end else if (PSEL_I && !PENABLE_I) begin
                PSLVERR_O <= !(hit(PADDR_I, `ITX_OFF_CTRL_SET) || hit(PADDR_I, `ITX_OFF_DATA)
                    || hit(PADDR_I, `ITX_OFF_SCL_HIGH) || hit(PADDR_I, `ITX_OFF_SCL_LOW)
                    || hit(PADDR_I, `ITX_OFF_CTRL_CLR) || hit(PADDR_I, `ITX_OFF_STATUS));
            end
        end
    end

    // Byte engine and bus sequencer
    always_ff @(posedge CLOCK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            st_q              <= ITX_IDLE;
            shift_q           <= 8'h00;
            tmr_q             <= 16'h0000;
            bit_q             <= 4'h0;
            scl_drv_low_q     <= 1'b0;
            sda_drv_low_q     <= 1'b0;
            arb_lost_q        <= 1'b0;
            addr_phase_q      <= 1'b0;
            was_start_q       <= 1'b0;
            mrx_q             <= 1'b0;
            ack_q             <= 1'b0;
        end else begin
            if (wr_acc && hit(PADDR_I, `ITX_OFF_DATA) && si) begin
                shift_q <= PWDATA_I[7:0];
            end
            if (!tmr_done) begin
                tmr_q <= tmr_q - 16'h0001;
            end
            if (!control_q[`ITX_BIT_EN]) begin
                st_q          <= ITX_IDLE;
                scl_drv_low_q <= 1'b0;
                sda_drv_low_q <= 1'b0;
                was_start_q   <= 1'b0;
                mrx_q         <= 1'b0;
            end else begin
                case (st_q)
                    ITX_IDLE: begin
                        scl_drv_low_q <= 1'b0;
                        sda_drv_low_q <= 1'b0;
                        if (control_q[`ITX_BIT_STA] && !si && bus_free) begin
                            sda_drv_low_q <= 1'b1;
                            tmr_q         <= scl_high_q;
                            was_start_q   <= 1'b0;
                            st_q          <= ITX_START;
                        end
                    end
                    ITX_START: begin
                        if (tmr_done) begin
                            scl_drv_low_q <= 1'b1;
                            addr_phase_q  <= 1'b1;
                            st_q          <= ITX_HOLD;
                        end
                    end
                    ITX_HOLD: begin
                        scl_drv_low_q <= 1'b1;
                        if (!si && ack_q) begin
                            ack_q <= 1'b0;
                        end
                        if (si) begin
                            ack_q <= 1'b1;
                        end else if (ack_q) begin
                            tmr_q <= scl_low_q;
                            bit_q <= 4'h0;
                            if (control_q[`ITX_BIT_STO]) begin
                                sda_drv_low_q     <= 1'b1;
                                st_q              <= ITX_STOP;
                            end else if (control_q[`ITX_BIT_STA] && !addr_phase_q) begin
                                sda_drv_low_q <= 1'b0;
                                st_q          <= ITX_RSTRT;
                            end else begin
                                if (addr_phase_q) begin
                                    mrx_q <= shift_q[0];
                                end
                                sda_drv_low_q <= !shift_q[7];
                                st_q          <= ITX_BITLO;
                            end
                        end
                    end
                    ITX_BITLO: begin
                        if (tmr_done) begin
                            scl_drv_low_q <= 1'b0;
                            if (scl_s_q) begin
                                tmr_q <= scl_high_q;
                                st_q  <= ITX_BITHI;
                            end
                        end
                    end
                    ITX_BITHI: begin
                        if (bit_q < 4'h8 && sda_drv_low_q == 1'b0 && !sda_s_q == 1'b1) begin
                            arb_lost_q <= 1'b1;
                        end
                        if (tmr_done) begin
                            scl_drv_low_q <= 1'b1;
                            tmr_q         <= scl_low_q;
                            if (bit_q < 4'h8) begin
                                shift_q <= {shift_q[6:0], sda_s_q};
                            end
                            if (bit_q == 4'h8) begin
                                sda_drv_low_q <= 1'b0;
                                addr_phase_q  <= 1'b0;
                                st_q          <= ITX_HOLD;
                            end else if (arb_lost_q) begin
                                sda_drv_low_q <= 1'b0;
                                bit_q         <= bit_q + 4'h1;
                                st_q          <= ITX_ARBW;
                            end else begin
                                // Bit 8 releases SDA for the slave's acknowledge
                                sda_drv_low_q <= (bit_q == 4'h7) ? 1'b0 : !shift_q[6];
                                bit_q         <= bit_q + 4'h1;
                                st_q          <= ITX_BITLO;
                            end
                        end
                    end
                    ITX_ARBW: begin
                        // Bus released at once; flag raised after a low period
                        scl_drv_low_q <= 1'b0;
                        sda_drv_low_q <= 1'b0;
                        if (tmr_done) begin
                            arb_lost_q <= 1'b0;
                            mrx_q      <= 1'b0;
                            st_q       <= ITX_IDLE;
                        end
                    end
                    ITX_STOP: begin
                        scl_drv_low_q <= !(tmr_q < (scl_low_q >> 1));
                        if (tmr_done) begin
                            sda_drv_low_q <= 1'b0;
                            mrx_q         <= 1'b0;
                            st_q          <= ITX_IDLE;
                        end
                    end
                    ITX_RSTRT: begin
                        if (tmr_done) begin
                            scl_drv_low_q <= 1'b0;
                            if (scl_s_q) begin
                                sda_drv_low_q <= 1'b1;
                                tmr_q         <= scl_high_q;
                                was_start_q   <= 1'b1;
                                st_q          <= ITX_START;
                            end
                        end
                    end
                    default: begin
                        st_q <= ITX_IDLE;
                    end
                endcase
            end
        end
    end

    // Open-drain outputs; enable low while pulling low
    always_ff @(posedge CLOCK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            SCL_O               <= 1'b1;
            SCL_OE_N_O          <= 1'b1;
            SDA_O               <= 1'b1;
            SDA_OE_N_O          <= 1'b1;
            sda_lag_q           <= 1'b0;
            MASTER_RECEIVE_OP_O <= 1'b0;
        end else begin
            SCL_O               <= 1'b0;
            SCL_OE_N_O          <= !scl_drv_low_q;
            SDA_O               <= 1'b0;
            // Data lags clock a cycle: no false START/STOP as SCL falls
            sda_lag_q           <= sda_drv_low_q;
            SDA_OE_N_O          <= !sda_lag_q;
            MASTER_RECEIVE_OP_O <= mrx_q;
        end
    end

    AST_HOLD_WHILE_FLAG: assert property (@(posedge CLOCK_I) disable iff (!NRST_I)
        (st_q == ITX_HOLD && si && control_q[`ITX_BIT_EN]) |=> st_q == ITX_HOLD)
        else $error("transfer moved while flag set");
    AST_START_CODE: assert property (@(posedge CLOCK_I) disable iff (!NRST_I)
        (si_set && st_q == ITX_START && !was_start_q) |=> state_code_q == 8'h08 && si)
        else $error("start code wrong");
    AST_DISABLED_IDLE: assert property (@(posedge CLOCK_I) disable iff (!NRST_I)
        !control_q[`ITX_BIT_EN] |=> st_q == ITX_IDLE)
        else $error("active while disabled");
    AST_STATUS_LOW_ZERO: assert property (@(posedge CLOCK_I) disable iff (!NRST_I)
        state_code_q[2:0] == 3'h0)
        else $error("status low bits nonzero");
    AST_STATUS_STABLE: assert property (@(posedge CLOCK_I) disable iff (!NRST_I)
        (si && $past(si) && !si_set) |-> $stable(state_code_q))
        else $error("status changed while flagged");
    AST_STOP_CLEARS: assert property (@(posedge CLOCK_I) disable iff (!NRST_I)
        (st_q == ITX_STOP && tmr_done && control_q[`ITX_BIT_EN]) |=> !control_q[`ITX_BIT_STO])
        else $error("stop bit not cleared");
    AST_SET_ALIAS: assert property (@(posedge CLOCK_I) disable iff (!NRST_I)
        (wr_acc && PADDR_I == `ITX_OFF_CTRL_SET && PWDATA_I[`ITX_BIT_EN]) |=> control_q[6])
        else $error("set alias failed");
    AST_DATA_CODE: assert property (@(posedge CLOCK_I) disable iff (!NRST_I)
        (si_set && !addr_phase_q && st_q == ITX_BITHI && !sda_s_q) |=> state_code_q == 8'h28)
        else $error("data ack code wrong");
endmodule

/* verif/itx_slave_model.sv */
`timescale 1ns/10ps
module itx_slave_model #(
    parameter logic [6:0] OWN_ADDR = 7'h50
) (
    input  wire logic       scl_i,
    input  wire logic       sda_i,
    input  wire logic       ack_en_i,
    output logic            sda_pull_o,
    output logic [7:0]      last_byte_o,
    output logic [7:0]      n_start_o,
    output logic [7:0]      n_stop_o
);
    logic [3:0] bit_cnt = 4'ha;
    logic [7:0] shift_q = 8'h00;
    logic       addr_ph = 1'b0;
    logic       sel     = 1'b0;
    initial begin
        sda_pull_o = 1'b0;
        last_byte_o = 8'h00;
        n_start_o = 8'h00;
        n_stop_o = 8'h00;
    end
    // Conditions count only while the clock line is high
    always @(negedge sda_i) if (scl_i === 1'b1) begin
        n_start_o++;
        bit_cnt = 4'h0;
        addr_ph = 1'b1;
    end
    // Open frame required, so power-up edges are not taken as a stop
    always @(posedge sda_i) if (scl_i === 1'b1 && bit_cnt != 4'ha) begin
        n_stop_o++;
        bit_cnt = 4'ha;
    end
    always @(posedge scl_i) if (bit_cnt < 4'h8) begin
        shift_q = {shift_q[6:0], sda_i};
        bit_cnt++;
    end
    // Ack moves on the falling clock so data never changes while clock is high
    always @(negedge scl_i) begin
        if (bit_cnt == 4'h8) begin
            last_byte_o = shift_q;
            if (addr_ph) sel = (shift_q[7:1] == OWN_ADDR);
            sda_pull_o = ack_en_i & sel;
            addr_ph = 1'b0;
            bit_cnt = 4'h9;
        end else if (bit_cnt == 4'h9) begin
            sda_pull_o = 1'b0;
            bit_cnt = 4'h0;
        end
    end
endmodule

/* verif/testbench.sv */
`timescale 1ns/10ps
`define CHK(nm, e, g) begin samples_checked++; if ((g) !== (e)) begin n_errors++; \
    $display("wrong value %s expected %h seen %h", nm, e, g); end end
module testbench;
    logic        clk = 1'b0;
    logic        rst_n = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic        ack_en = 1'b1;
    logic        other_low = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata, rdat;
    logic        pready, pslverr, err, scl_o, scl_oe_n, sda_o, sda_oe_n, recv_op, sda_pull;
    logic [7:0]  last_byte, n_start, n_stop;
    int          n_errors = 0;
    int          samples_checked = 0;
    int          cyc = 0;
    // Both lines have pull-ups: released means high
    wire         scl_w = scl_oe_n | scl_o;
    wire         sda_w = (sda_oe_n | sda_o) & ~sda_pull & ~other_low;
    always #2 clk = ~clk;
    itx_master_tx dut (.CLOCK_I(clk), .NRST_I(rst_n), .PSEL_I(psel), .PENABLE_I(penable),
        .PWRITE_I(pwrite), .PADDR_I(paddr), .PWDATA_I(pwdata), .PRDATA_O(prdata),
        .PREADY_O(pready), .PSLVERR_O(pslverr), .SCL_I(scl_w), .SCL_O(scl_o),
        .SCL_OE_N_O(scl_oe_n), .SDA_I(sda_w), .SDA_O(sda_o), .SDA_OE_N_O(sda_oe_n),
        .MASTER_RECEIVE_OP_O(recv_op));
    itx_slave_model slave (.scl_i(scl_w), .sda_i(sda_w), .ack_en_i(ack_en),
        .sda_pull_o(sda_pull), .last_byte_o(last_byte), .n_start_o(n_start), .n_stop_o(n_stop));
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1) begin
            @(posedge clk);
        end
        rdat = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask
    task automatic step(input logic [7:0] d, input logic [7:0] set, input logic [7:0] clr,
                        input logic [7:0] st, input string nm);
        apb(1'b1, 12'h008, {24'h0, d});
        apb(1'b1, 12'h000, {24'h0, set});
        apb(1'b1, 12'h018, {24'h0, clr});
        apb(1'b0, 12'h000, 32'h0);
        while (rdat[3] !== 1'b1) begin
            apb(1'b0, 12'h000, 32'h0);
        end
        apb(1'b0, 12'h004, 32'h0);
        `CHK(nm, st, rdat[7:0])
        $display("test %s done", nm);
    endtask
    task automatic conclude();
        $display("checks %0d mismatches %0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    // Whole run needs about 6000 cycles
    always @(posedge clk) begin
        cyc++;
        if (cyc == 40000) begin
            n_errors++;
            conclude();
        end
    end
    initial begin
        repeat (16) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        apb(1'b0, 12'h004, 32'h0);
        `CHK("status reset", 8'hf8, rdat[7:0])
        apb(1'b0, 12'h010, 32'h0);
        `CHK("scl high reset", 32'h4, rdat)
        apb(1'b0, 12'h00c, 32'h0);
        `CHK("unmapped", 1'b1, err)
        apb(1'b1, 12'h000, 32'h24);
        apb(1'b1, 12'h018, 32'h04);
        apb(1'b0, 12'h000, 32'h0);
        `CHK("set clear", 32'h20, rdat)
        repeat (1500) @(posedge clk);
        `CHK("idle when off", 8'h0, n_start)
        $display("test regs done");
        apb(1'b1, 12'h010, 32'h8);
        apb(1'b1, 12'h014, 32'h8);
        step(8'h00, 8'h40, 8'h00, 8'h08, "start");
        `CHK("starts", 8'h1, n_start)
        step(8'ha0, 8'h00, 8'h28, 8'h18, "addr ack");
        `CHK("addr byte", 8'ha0, last_byte)
        step(8'h3c, 8'h00, 8'h08, 8'h28, "data ack");
        `CHK("data byte", 8'h3c, last_byte)
        ack_en <= 1'b0;
        step(8'h5a, 8'h00, 8'h08, 8'h30, "data nack");
        ack_en <= 1'b1;
        repeat (100) @(posedge clk);
        `CHK("scl held", 1'b0, scl_w)
        step(8'h00, 8'h20, 8'h08, 8'h10, "rstart");
        `CHK("restarts", 8'h2, n_start)
        step(8'ha2, 8'h00, 8'h28, 8'h20, "addr nack");
        apb(1'b1, 12'h000, 32'h10);
        apb(1'b1, 12'h018, 32'h08);
        repeat (300) @(posedge clk);
        apb(1'b0, 12'h000, 32'h0);
        `CHK("stop bit", 1'b0, rdat[4])
        `CHK("stops", 8'h1, n_stop)
        step(8'h00, 8'h20, 8'h00, 8'h08, "start again");
        step(8'ha0, 8'h00, 8'h28, 8'h18, "addr ack 2");
        step(8'h00, 8'h30, 8'h08, 8'h08, "stop start");
        `CHK("stop start", 8'h2, n_stop)
        apb(1'b0, 12'h000, 32'h0);
        `CHK("stop bit 2", 1'b0, rdat[4])
        step(8'ha0, 8'h00, 8'h28, 8'h18, "addr ack 3");
        step(8'h00, 8'h20, 8'h08, 8'h10, "rstart 2");
        step(8'ha1, 8'h00, 8'h28, 8'h40, "addr read");
        `CHK("receive op", 1'b1, recv_op)
        // A rival master holds SDA low while this block sends a one
        other_low <= 1'b1;
        step(8'hff, 8'h00, 8'h08, 8'h38, "arb lost");
        other_low <= 1'b0;
        `CHK("released op", 1'b0, recv_op)
        conclude();
    end
endmodule
